// ---- aer_severity_correctable_status.sv ----
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "aer_regs.svh"

// What this block does
// - Unmasked uncorrectable event reports fatal if severity set, else non-fatal
// - Severity bit 19 selects end-to-end CRC error severity, read-write, resets zero
// - Severity bit 20 selects unsupported request severity, read-write, resets zero
// - Severity bit 21 selects access control violation severity, read-write, resets zero
// - Severity bit 31 for double bit errors; when disabled it reads zero and any write clears it
// - Correctable bit 0 sets on receiver error; writing one clears it
// - Correctable bit 6 sets on bad packet; writing one clears it
// - Correctable bit 7 sets on bad link packet; writing one clears it
// - Correctable bit 8 sets on replay number rollover
// - Correctable bit 12 sets on replay timer expiry
// - Correctable bit 13 sets on advisory non-fatal error
// - Correctable bit 31 sets on memory single bit error when reporting enabled
// - With single bit reporting disabled, bit 31 reads zero and ignores writes
// - Masked uncorrectable event still sets status but is never reported
// - Masked correctable event is not reported to the root complex
module aer_severity_correctable_status (
   // Clock and resets
   input  wire logic           clock,
   input  wire logic           sys_rst,
   input  wire logic           por_rst,
   // APB register port
   input  wire logic           psel,
   input  wire logic           penable,
   input  wire logic           pwrite,
   input  wire aer_pkg::addr_t paddr,
   input  wire aer_pkg::word_t pwdata,
   input  wire aer_pkg::strb_t pstrb,
   output logic                pready,
   output aer_pkg::word_t      prdata,
   output logic                pslverr,
   // Uncorrectable events from port logic
   input  wire logic           ecrcError,
   input  wire logic           unsupportedRequest,
   input  wire logic           accessControlViolation,
   input  wire logic           doubleBitError,
   // Correctable events from port logic
   input  wire logic           receiverError,
   input  wire logic           badPacket,
   input  wire logic           badLinkPacket,
   input  wire logic           replayRollover,
   input  wire logic           replayTimeout,
   input  wire logic           advisoryNonfatal,
   input  wire logic           singleBitError,
   // Reports toward the root complex
   output logic                fatalReport_q,
   output logic                nonfatalReport_q,
   output logic                correctableReport_q,
   // Interrupt
   output logic                irq_q
);
   import aer_pkg::*;

   // Stored words
   word_t    ueSeverity_q;
   word_t    ueMask_q;
   word_t    ceMask_q;
   word_t    memCtl_q;
   word_t    irqMask_q;

   // Flag banks, views and vectors
   word_t    ueStatus;
   word_t    ceStatus;
   word_t    irqStatus;
   word_t    readData;
   word_t    byteMask;
   word_t    w1cBits;
   word_t    ueEvents;
   word_t    ceEvents;
   word_t    ueGate;
   word_t    ceGate;
   word_t    ueSevView;
   word_t    ueMaskView;
   word_t    ceMaskView;
   word_t    ceStatusView;
   word_t    ueReportable;
   word_t    ceReportable;
   word_t    irqSet;
   word_t    ueStatusClr;
   word_t    ceStatusClr;
   word_t    irqStatusClr;

   // Bus decode and gating
   reg_sel_t regSel;
   logic     wrStrobe;
   logic     dbeEnable;
   logic     sbeEnable;
   logic     nonstickyRst;
   logic     fatalNow;
   logic     nonfatalNow;
   logic     correctableNow;

   // Write enables
   logic     wrUeMask;
   logic     wrUeSev;
   logic     wrCeMask;
   logic     wrMemCtl;
   logic     wrIrqMask;

   function automatic reg_sel_t decodeAddr(input addr_t addr);
      case (addr)
         `AER_UE_STATUS_OFF:   decodeAddr = SEL_UE_STATUS;
         `AER_UE_MASK_OFF:     decodeAddr = SEL_UE_MASK;
         `AER_UE_SEVERITY_OFF: decodeAddr = SEL_UE_SEVERITY;
         `AER_CE_STATUS_OFF:   decodeAddr = SEL_CE_STATUS;
         `AER_CE_MASK_OFF:     decodeAddr = SEL_CE_MASK;
         `AER_MEM_CTL_OFF:     decodeAddr = SEL_MEM_CTL;
         `AER_IRQ_STATUS_OFF:  decodeAddr = SEL_IRQ_STATUS;
         `AER_IRQ_MASK_OFF:    decodeAddr = SEL_IRQ_MASK;
         default:              decodeAddr = SEL_NONE;
      endcase
   endfunction

   // Byte-lane merge of a read-write register, limited to its live bits
   function automatic word_t mergeWrite(input word_t cur, input word_t data,
                                        input word_t lanes, input word_t impl);
      mergeWrite = ((cur & ~lanes) | (data & lanes)) & impl;
   endfunction

   function automatic word_t gateBit(input logic en, input int pos);
      gateBit = en ? 32'hffff_ffff : ~(32'h0000_0001 << pos);
   endfunction

   // Power-on also clears everything that is not sticky
   assign nonstickyRst = sys_rst | por_rst;
   assign regSel       = decodeAddr(paddr);
   assign byteMask     = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
   assign w1cBits      = wrStrobe ? (pwdata & byteMask) : 32'h0000_0000;

   // Closed gates hide bit 31 in severity, both masks and correctable status
   assign dbeEnable = memCtl_q[`AER_MEM_DBE_EN_BIT];
   assign sbeEnable = memCtl_q[`AER_MEM_SBE_EN_BIT];
   assign ueGate    = gateBit(dbeEnable, `AER_UE_DBE_BIT);
   assign ceGate    = gateBit(sbeEnable, `AER_CE_SBE_BIT);

   apb_reg_port u_apb (
      .clock    (clock),
      .sys_rst  (nonstickyRst),
      .psel     (psel),
      .penable  (penable),
      .pwrite   (pwrite),
      .pready   (pready),
      .prdata   (prdata),
      .pslverr  (pslverr),
      .readData (readData),
      .readHit  (regSel != SEL_NONE),
      .wrStrobe (wrStrobe)
   );

   // Memory error control, gates the double and single bit fields
   always_ff @(posedge clock) begin
      if (por_rst) begin
         memCtl_q <= `AER_MEM_CTL_RST;
      end else if (wrMemCtl) begin
         memCtl_q <= mergeWrite(memCtl_q, pwdata, byteMask, `AER_MEM_IMPL);
      end
   end

   // Severity selectors; any write loads zero into bit 31 while double bit reporting is off
   always_ff @(posedge clock) begin
      if (por_rst) begin
         ueSeverity_q <= `AER_UE_SEVERITY_RST;
      end else if (wrUeSev) begin
         ueSeverity_q <= mergeWrite(ueSeverity_q, pwdata, byteMask, `AER_UE_IMPL & ueGate);
      end
   end

   always_ff @(posedge clock) begin
      if (por_rst) begin
         ueMask_q <= `AER_UE_MASK_RST;
      end else if (wrUeMask) begin
         ueMask_q <= mergeWrite(ueMask_q, pwdata, byteMask, `AER_UE_IMPL & ueGate);
      end
   end

   always_ff @(posedge clock) begin
      if (por_rst) begin
         ceMask_q <= `AER_CE_MASK_RST;
      end else if (wrCeMask) begin
         ceMask_q <= mergeWrite(ceMask_q, pwdata, byteMask, `AER_CE_IMPL & ceGate);
      end
   end

   // Held value is hidden while a gate is closed; a write to the register then clears bit 31
   assign ueSevView  = ueSeverity_q & ueGate;
   assign ueMaskView = ueMask_q & ueGate;
   assign ceMaskView = ceMask_q & ceGate;

   always_comb begin
      ueEvents = 32'h0000_0000;
      ueEvents[`AER_UE_ECRC_BIT] = ecrcError;
      ueEvents[`AER_UE_UR_BIT]   = unsupportedRequest;
      ueEvents[`AER_UE_ACCESS_CONTROL_VIOLATION_BIT] = accessControlViolation;
      ueEvents[`AER_UE_DBE_BIT]  = doubleBitError & dbeEnable;
   end

   always_comb begin
      ceEvents = 32'h0000_0000;
      ceEvents[`AER_CE_RCV_BIT]     = receiverError;
      ceEvents[`AER_CE_BAD_PACKET_FLAG_BIT]  = badPacket;
      ceEvents[`AER_CE_BADLINK_BIT] = badLinkPacket;
      ceEvents[`AER_CE_ROLL_BIT]    = replayRollover;
      ceEvents[`AER_CE_RTO_BIT]     = replayTimeout;
      ceEvents[`AER_CE_ADV_BIT]     = advisoryNonfatal;
      ceEvents[`AER_CE_SBE_BIT]     = singleBitError & sbeEnable;
   end

   // One write enable per read-write register word, decoded once
   always_comb begin
      wrUeMask  = 1'b0;
      wrUeSev   = 1'b0;
      wrCeMask  = 1'b0;
      wrMemCtl  = 1'b0;
      wrIrqMask = 1'b0;
      if (wrStrobe) begin
         case (regSel)
            SEL_UE_MASK:     wrUeMask  = 1'b1;
            SEL_UE_SEVERITY: wrUeSev   = 1'b1;
            SEL_CE_MASK:     wrCeMask  = 1'b1;
            SEL_MEM_CTL:     wrMemCtl  = 1'b1;
            SEL_IRQ_MASK:    wrIrqMask = 1'b1;
            default:         wrUeMask  = 1'b0;
         endcase
      end
   end

   // Write-one-to-clear reaches only the addressed status word
   always_comb begin
      ueStatusClr  = 32'h0000_0000;
      ceStatusClr  = 32'h0000_0000;
      irqStatusClr = 32'h0000_0000;
      case (regSel)
         SEL_UE_STATUS:  ueStatusClr  = w1cBits;
         SEL_CE_STATUS:  ceStatusClr  = w1cBits;
         SEL_IRQ_STATUS: irqStatusClr = w1cBits;
         default:        irqStatusClr = 32'h0000_0000;
      endcase
   end

   // Status is recorded whether or not the event is masked
   sticky_flag_bank #(
      .WIDTH     (32),
      .RESET_VAL (`AER_UE_STATUS_RST),
      .IMPL      (`AER_UE_IMPL)
   ) u_ue_status (
      .clock   (clock),
      .rst     (por_rst),
      .setVec  (ueEvents),
      .clrVec  (ueStatusClr),
      .flags_q (ueStatus)
   );

   sticky_flag_bank #(
      .WIDTH     (32),
      .RESET_VAL (`AER_CE_STATUS_RST),
      .IMPL      (`AER_CE_IMPL)
   ) u_ce_status (
      .clock   (clock),
      .rst     (por_rst),
      .setVec  (ceEvents),
      .clrVec  (ceStatusClr & ceGate),
      .flags_q (ceStatus)
   );

   assign ceStatusView = ceStatus & ceGate;

   // Reporting acts on the event level in each cycle, not the held status
   assign ueReportable   = ueEvents & ~ueMaskView;
   assign ceReportable   = ceEvents & ~ceMaskView;
   assign fatalNow       = |(ueReportable & ueSevView);
   assign nonfatalNow    = |(ueReportable & ~ueSevView);
   assign correctableNow = |ceReportable;

   // Report pulses, one cycle after the event
   always_ff @(posedge clock) begin
      if (nonstickyRst) begin
         fatalReport_q       <= 1'b0;
         nonfatalReport_q    <= 1'b0;
         correctableReport_q <= 1'b0;
      end else begin
         fatalReport_q       <= fatalNow;
         nonfatalReport_q    <= nonfatalNow;
         correctableReport_q <= correctableNow;
      end
   end

   // Interrupt causes, one per report class
   always_comb begin
      irqSet = 32'h0000_0000;
      irqSet[`AER_IRQ_CORR_BIT]     = correctableNow;
      irqSet[`AER_IRQ_NONFATAL_BIT] = nonfatalNow;
      irqSet[`AER_IRQ_FATAL_BIT]    = fatalNow;
   end

   // Set wins, so a cause during its clear is kept
   sticky_flag_bank #(
      .WIDTH     (32),
      .RESET_VAL (`AER_IRQ_RST),
      .IMPL      (`AER_IRQ_IMPL)
   ) u_irq_status (
      .clock   (clock),
      .rst     (nonstickyRst),
      .setVec  (irqSet),
      .clrVec  (irqStatusClr),
      .flags_q (irqStatus)
   );

   always_ff @(posedge clock) begin
      if (nonstickyRst) begin
         irqMask_q <= `AER_IRQ_RST;
      end else if (wrIrqMask) begin
         irqMask_q <= mergeWrite(irqMask_q, pwdata, byteMask, `AER_IRQ_IMPL);
      end
   end

   // Registered so the pin never glitches; lags status by one cycle
   always_ff @(posedge clock) begin
      if (nonstickyRst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irqStatus & irqMask_q);
      end
   end

   // Unimplemented bits are already zero in every stored word
   always_comb begin
      case (regSel)
         SEL_UE_STATUS:   readData = ueStatus;
         SEL_UE_MASK:     readData = ueMaskView;
         SEL_UE_SEVERITY: readData = ueSevView;
         SEL_CE_STATUS:   readData = ceStatusView;
         SEL_CE_MASK:     readData = ceMaskView;
         SEL_MEM_CTL:     readData = memCtl_q;
         SEL_IRQ_STATUS:  readData = irqStatus;
         SEL_IRQ_MASK:    readData = irqMask_q;
         default:         readData = 32'h0000_0000;
      endcase
   end

endmodule

// ---- aer_regs.svh ----
`ifndef AER_REGS_SVH
`define AER_REGS_SVH

// Byte offsets of the register words
`define AER_UE_STATUS_OFF   12'h104
`define AER_UE_MASK_OFF     12'h108
`define AER_UE_SEVERITY_OFF 12'h10c
`define AER_CE_STATUS_OFF   12'h110
`define AER_CE_MASK_OFF     12'h114
`define AER_MEM_CTL_OFF     12'h130
`define AER_IRQ_STATUS_OFF  12'h140
`define AER_IRQ_MASK_OFF    12'h144

// Uncorrectable field positions
`define AER_UE_ECRC_BIT     19
`define AER_UE_UR_BIT       20
`define AER_UE_ACCESS_CONTROL_VIOLATION_BIT     21
`define AER_UE_DBE_BIT      31

// Correctable field positions
`define AER_CE_RCV_BIT      0
`define AER_CE_BAD_PACKET_FLAG_BIT   6
`define AER_CE_BADLINK_BIT  7
`define AER_CE_ROLL_BIT     8
`define AER_CE_RTO_BIT      12
`define AER_CE_ADV_BIT      13
`define AER_CE_SBE_BIT      31

// Memory error control field positions
`define AER_MEM_DBE_EN_BIT  0
`define AER_MEM_SBE_EN_BIT  1

// Interrupt status and mask field positions
`define AER_IRQ_CORR_BIT    0
`define AER_IRQ_NONFATAL_BIT 1
`define AER_IRQ_FATAL_BIT   2

// Implemented bits and reset values
`define AER_UE_IMPL         32'h8038_0000
`define AER_CE_IMPL         32'h8000_31c1
`define AER_MEM_IMPL        32'h0000_0003
`define AER_IRQ_IMPL        32'h0000_0007
`define AER_UE_STATUS_RST   32'h0000_0000
`define AER_UE_MASK_RST     32'h0000_0000
`define AER_UE_SEVERITY_RST 32'h0000_0000
`define AER_CE_STATUS_RST   32'h0000_0000
`define AER_CE_MASK_RST     32'h0000_2000
`define AER_MEM_CTL_RST     32'h0000_0000
`define AER_IRQ_RST         32'h0000_0000

`endif

// ---- aer_pkg.sv ----
package aer_pkg;

   typedef logic [31:0] word_t;
   typedef logic [11:0] addr_t;
   typedef logic [3:0]  strb_t;

   typedef enum logic [3:0] {
      SEL_NONE,
      SEL_UE_STATUS,
      SEL_UE_MASK,
      SEL_UE_SEVERITY,
      SEL_CE_STATUS,
      SEL_CE_MASK,
      SEL_MEM_CTL,
      SEL_IRQ_STATUS,
      SEL_IRQ_MASK
   } reg_sel_t;

endpackage

// ---- sticky_flag_bank.sv ----
`timescale 1ns/1ps
module sticky_flag_bank #(
   parameter int          WIDTH     = 32,
   parameter logic [31:0] RESET_VAL = 32'h0000_0000,
   parameter logic [31:0] IMPL      = 32'hffff_ffff
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst,
   // Event and clear vectors
   input  wire logic [WIDTH-1:0] setVec,
   input  wire logic [WIDTH-1:0] clrVec,
   // Flag state
   output logic      [WIDTH-1:0] flags_q
);

   // Set beats clear so an event in the clearing cycle is kept
   function automatic logic [WIDTH-1:0] nextFlags(input logic [WIDTH-1:0] cur,
                                                  input logic [WIDTH-1:0] set,
                                                  input logic [WIDTH-1:0] clr);
      nextFlags = (cur & ~clr) | set;
   endfunction

   always_ff @(posedge clock) begin
      if (rst) begin
         flags_q <= RESET_VAL[WIDTH-1:0];
      end else begin
         flags_q <= nextFlags(flags_q, setVec, clrVec) & IMPL[WIDTH-1:0];
      end
   end

endmodule

// ---- apb_reg_port.sv ----
`timescale 1ns/1ps
module apb_reg_port (
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          sys_rst,
   // APB slave side
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   output logic               pready,
   output aer_pkg::word_t     prdata,
   output logic               pslverr,
   // Register file side
   input  wire aer_pkg::word_t readData,
   input  wire logic          readHit,
   output logic               wrStrobe
);
   import aer_pkg::*;

   logic accessPhase;

   assign accessPhase = psel & penable;
   // Writes land only on the completing edge of the access phase
   assign wrStrobe    = accessPhase & pready & pwrite;

   // One wait state, so read data is captured from stable address
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pready <= 1'b0;
      end else begin
         pready <= accessPhase & ~pready;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (accessPhase & ~pready) begin
         prdata  <= pwrite ? 32'h0000_0000 : readData;
         pslverr <= ~readHit;
      end else begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

endmodule

// ---- root_complex_model.sv ----
`timescale 1ns/1ps
module root_complex_model (
   // Clock
   input  wire logic clock,
   // Error messages from the switch port
   input  wire logic fatalReport_q,
   input  wire logic nonfatalReport_q,
   input  wire logic correctableReport_q,
   // Message tallies
   output int        fatalCount_q,
   output int        nonfatalCount_q,
   output int        corrCount_q
);
   // Only tallies; error messages are never refused or delayed
   always @(posedge clock) begin
      if (fatalReport_q === 1'b1) fatalCount_q <= fatalCount_q + 1;
      if (nonfatalReport_q === 1'b1) nonfatalCount_q <= nonfatalCount_q + 1;
      if (correctableReport_q === 1'b1) corrCount_q <= corrCount_q + 1;
   end
endmodule

// ---- aer_severity_correctable_status_properties.sv ----
`timescale 1ns/1ps
`include "aer_regs.svh"
module aer_severity_correctable_status_properties (
   // Clock and resets
   input  wire logic           clock,
   input  wire logic           sys_rst,
   input  wire logic           por_rst,
   // APB
   input  wire logic           psel,
   input  wire logic           penable,
   input  wire logic           pwrite,
   input  wire aer_pkg::addr_t paddr,
   input  wire logic           pready,
   input  wire aer_pkg::word_t prdata,
   input  wire logic           pslverr,
   // Events
   input  wire logic           ecrcError,
   input  wire logic           unsupportedRequest,
   input  wire logic           accessControlViolation,
   input  wire logic           doubleBitError,
   input  wire logic           receiverError,
   input  wire logic           badPacket,
   input  wire logic           badLinkPacket,
   input  wire logic           replayRollover,
   input  wire logic           replayTimeout,
   input  wire logic           advisoryNonfatal,
   input  wire logic           singleBitError,
   // Reports and interrupt
   input  wire logic           fatalReport_q,
   input  wire logic           nonfatalReport_q,
   input  wire logic           correctableReport_q,
   input  wire logic           irq_q
);
   import aer_pkg::*;
   logic ueAny;
   logic ceAny;
   assign ueAny = ecrcError | unsupportedRequest | accessControlViolation | doubleBitError;
   assign ceAny = receiverError | badPacket | badLinkPacket | replayRollover | replayTimeout
                  | advisoryNonfatal | singleBitError;
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst || por_rst);
   a_ready_one_wait: assert property (psel && $rose(penable) |=> pready) else $error("no answer after one wait");
   a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
   a_error_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
   a_idle_data_zero: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
   a_fatal_cause: assert property (fatalReport_q |-> $past(ueAny)) else $error("fatal without event");
   a_nonfatal_cause: assert property (nonfatalReport_q |-> $past(ueAny)) else $error("nonfatal without event");
   a_corr_cause: assert property (correctableReport_q |-> $past(ceAny)) else $error("corr without event");
   a_ce_reserved_zero: assert property (pready && !pwrite && paddr == `AER_CE_STATUS_OFF
      |-> (prdata & ~`AER_CE_IMPL) == 32'h0) else $error("status reserved bits set");
   a_sev_reserved_zero: assert property (pready && !pwrite && paddr == `AER_UE_SEVERITY_OFF
      |-> (prdata & ~`AER_UE_IMPL) == 32'h0) else $error("severity reserved bits set");
   a_irq_has_cause: assert property ($rose(irq_q) |-> $past(fatalReport_q | nonfatalReport_q
      | correctableReport_q) || $past(pready && pwrite, 2)) else $error("interrupt without cause");
endmodule
bind aer_severity_correctable_status aer_severity_correctable_status_properties u_props (
   .clock(clock), .sys_rst(sys_rst), .por_rst(por_rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .ecrcError(ecrcError), .unsupportedRequest(unsupportedRequest),
   .accessControlViolation(accessControlViolation), .doubleBitError(doubleBitError),
   .receiverError(receiverError), .badPacket(badPacket), .badLinkPacket(badLinkPacket),
   .replayRollover(replayRollover), .replayTimeout(replayTimeout), .advisoryNonfatal(advisoryNonfatal),
   .singleBitError(singleBitError), .fatalReport_q(fatalReport_q), .nonfatalReport_q(nonfatalReport_q),
   .correctableReport_q(correctableReport_q), .irq_q(irq_q));

// ---- aer_severity_correctable_status_tb_top.sv ----
`timescale 1ns/1ps
`include "aer_regs.svh"
module aer_severity_correctable_status_tb_top;
   import aer_pkg::*;
   logic        clock, sys_rst, por_rst, psel, penable, pwrite, pready, pslverr, errv;
   logic        fatalReport_q, nonfatalReport_q, correctableReport_q, irq_q;
   addr_t       paddr;
   word_t       pwdata, prdata, rdv, sev, uem, cem;
   strb_t       pstrb;
   logic [10:0] evt, v;
   logic [2:0]  rep;
   int          fatalCount_q, nonfatalCount_q, corrCount_q, f0, n0, c0, miscompares, num_checks;
   int          ueBit [4] = '{19, 20, 21, 31};
   int          ceBit [7] = '{0, 6, 7, 8, 12, 13, 31};

   aer_severity_correctable_status DUT (.clock(clock), .sys_rst(sys_rst), .por_rst(por_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .ecrcError(evt[0]), .unsupportedRequest(evt[1]),
      .accessControlViolation(evt[2]), .doubleBitError(evt[3]), .receiverError(evt[4]), .badPacket(evt[5]),
      .badLinkPacket(evt[6]), .replayRollover(evt[7]), .replayTimeout(evt[8]), .advisoryNonfatal(evt[9]),
      .singleBitError(evt[10]), .fatalReport_q(fatalReport_q), .nonfatalReport_q(nonfatalReport_q),
      .correctableReport_q(correctableReport_q), .irq_q(irq_q));
   root_complex_model rc (.clock(clock), .fatalReport_q(fatalReport_q), .nonfatalReport_q(nonfatalReport_q),
      .correctableReport_q(correctableReport_q), .fatalCount_q(fatalCount_q),
      .nonfatalCount_q(nonfatalCount_q), .corrCount_q(corrCount_q));

   // Status word that a set of event pulses should leave behind
   function automatic word_t spread(logic [10:0] v, logic ue);
      word_t w = '0;
      for (int i = 0; i < 4; i++) if (ue && v[i]) w[ueBit[i]] = 1'b1;
      for (int i = 0; i < 7; i++) if (!ue && v[4+i]) w[ceBit[i]] = 1'b1;
      return w;
   endfunction
   // Report classes expected: bit2 fatal, bit1 nonfatal, bit0 correctable
   function automatic logic [2:0] expRep(logic [10:0] v, word_t s, word_t um, word_t cm);
      logic [2:0] r = '0;
      for (int i = 0; i < 4; i++) if (v[i] && !um[ueBit[i]]) r[s[ueBit[i]] ? 2 : 1] = 1'b1;
      for (int i = 0; i < 7; i++) if (v[4+i] && !cm[ceBit[i]]) r[0] = 1'b1;
      return r;
   endfunction
   task automatic chk_word(input word_t got, input word_t exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask
   task automatic apb(input addr_t a, input logic w, input word_t d, input strb_t s);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) miscompares++;
      @(posedge clock);
   endtask
   task automatic wr(input addr_t a, input word_t d);
      apb(a, 1'b1, d, 4'hf);
   endtask
   task automatic rd_chk(input addr_t a, input word_t exp);
      apb(a, 1'b0, 32'h0, 4'h0);
      chk_word(rdv, exp);
   endtask
   task automatic pulse(input logic [10:0] v);
      evt <= v;
      @(posedge clock);
      evt <= '0;
      repeat (3) @(posedge clock);
   endtask
   task automatic close_out;
      $display("checks=%0d miscompares=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      close_out();
   end
   initial begin
      {sys_rst, por_rst, psel, penable, pwrite, paddr, pwdata, pstrb, evt} = {2'b11, 62'h0};
      void'($urandom(32'h0be5669a));
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      por_rst <= 1'b0;
      @(posedge clock);
      rd_chk(`AER_UE_SEVERITY_OFF, 32'h0);
      rd_chk(`AER_CE_STATUS_OFF, 32'h0);
      rd_chk(`AER_CE_MASK_OFF, 32'h0000_2000);
      rd_chk(12'h200, 32'h0);
      chk_flag(errv, 1'b1);
      // Gated bits stay zero while both memory report enables are off
      wr(`AER_UE_SEVERITY_OFF, 32'hffff_ffff);
      pulse(11'h400);
      rd_chk(`AER_CE_STATUS_OFF, 32'h0);
      wr(`AER_MEM_CTL_OFF, 32'h3);
      rd_chk(`AER_UE_SEVERITY_OFF, 32'h0038_0000);
      wr(`AER_CE_MASK_OFF, 32'h0);
      pulse(11'h7f0);
      rd_chk(`AER_CE_STATUS_OFF, 32'h8000_31c1);
      apb(`AER_CE_STATUS_OFF, 1'b1, 32'hffff_ffff, 4'h1);
      rd_chk(`AER_CE_STATUS_OFF, 32'h8000_3100);
      // Sticky status survives an ordinary reset, not a power-on one
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      rd_chk(`AER_CE_STATUS_OFF, 32'h8000_3100);
      wr(`AER_IRQ_MASK_OFF, 32'h1);
      pulse(11'h010);
      chk_flag(irq_q, 1'b1);
      wr(`AER_IRQ_STATUS_OFF, 32'h7);
      @(posedge clock);
      chk_flag(irq_q, 1'b0);
      por_rst <= 1'b1;
      repeat (2) @(posedge clock);
      por_rst <= 1'b0;
      @(posedge clock);
      rd_chk(`AER_CE_STATUS_OFF, 32'h0);
      wr(`AER_MEM_CTL_OFF, 32'h3);
      for (int k = 0; k < 40; k++) begin
         sev = $urandom;
         uem = (k < 4) ? 32'h0 : $urandom;
         cem = $urandom;
         wr(`AER_UE_SEVERITY_OFF, sev);
         rd_chk(`AER_UE_SEVERITY_OFF, sev & `AER_UE_IMPL);
         wr(`AER_UE_MASK_OFF, uem);
         wr(`AER_CE_MASK_OFF, cem);
         wr(`AER_UE_STATUS_OFF, 32'hffff_ffff);
         wr(`AER_CE_STATUS_OFF, 32'hffff_ffff);
         {f0, n0, c0} = {fatalCount_q, nonfatalCount_q, corrCount_q};
         v = 11'($urandom) | ((k % 3 == 0) ? 11'h7ff : 11'h000);
         rep = expRep(v, sev, uem, cem);
         pulse(v);
         chk_word(word_t'(fatalCount_q - f0), {31'h0, rep[2]});
         chk_word(word_t'(nonfatalCount_q - n0), {31'h0, rep[1]});
         chk_word(word_t'(corrCount_q - c0), {31'h0, rep[0]});
         rd_chk(`AER_UE_STATUS_OFF, spread(v, 1'b1));
         rd_chk(`AER_CE_STATUS_OFF, spread(v, 1'b0));
      end
      close_out();
   end
endmodule
